// ===== hdl/dual_dac_serial_load.sv
// Serial load and output update logic of a dual 12-bit converter.
// Assumes SCLK, SDATA and the frame strobe come from the host, and the update
// strobe is an unsynchronised pin; MCLK is the system clock at 125 MHz.
`timescale 1ns/1ps
//
// Contract
// - A frame starts when the frame strobe goes low and bits are taken only while it stays low.
// - Each data bit is valid at a falling serial clock edge and is sampled on each of the first 16 falling edges of the frame.
// - Bit 12 of the frame picks the channel: zero loads channel A, one loads channel B.
// - While the update strobe stays high across writes the outputs do not change.
// - After the second write the host lowers the update strobe and both outputs take their latches at once.
// - With the update strobe held low the addressed output updates on the 16th falling edge of the frame; this logic updates it six MCLK rising edges later.
// - The joint update is caused by the falling edge of the update strobe, not by its low level.
module dual_dac_serial_load
    import dac_load_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SCLK,
    input wire logic SDATA,
    input wire logic HOST_FRAME_STROBE_N,
    input wire logic OUTPUT_UPDATE_N,
    output logic [CODE_W-1:0] CODE_A,
    output logic [CODE_W-1:0] CODE_B,
    output logic BUF_READY
);
    function automatic logic chan_of(input load_word_t w);
        chan_of = w[SEL_POS];
    endfunction

    function automatic code_t code_of(input load_word_t w);
        code_of = w[CODE_W-1:0];
    endfunction

    // Link domain, falling edge of SCLK
    logic [CNT_W-1:0] bit_cnt_reg;
    logic [FRAME_BITS-1:0] shift_reg;
    load_word_t word_reg;
    logic word_tgl_reg;
    wire frame_active = !HOST_FRAME_STROBE_N;
    wire last_edge = frame_active && (bit_cnt_reg == LAST_EDGE);
    wire take_bit = frame_active && (bit_cnt_reg != FRAME_DONE);

    // The strobe itself clears the count, so a stopped SCLK between frames is harmless;
    // reset clears it too, as the strobe may sit high from power-up and never rise
    wire link_clear = HOST_FRAME_STROBE_N || RST;

    always_ff @(negedge SCLK or posedge link_clear)
    begin
        if (link_clear)
        begin
            bit_cnt_reg <= CNT_ZERO;
        end
        else if (take_bit)
        begin
            bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
        end
    end

    always_ff @(negedge SCLK)
    begin
        if (take_bit)
        begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], SDATA};
        end
        if (last_edge)
        begin
            word_reg <= {shift_reg[WORD_W-2:0], SDATA};
        end
    end

    // Toggle marks a completed word; word_reg then stays put for a whole frame
    always_ff @(negedge SCLK or posedge RST)
    begin
        if (RST)
        begin
            word_tgl_reg <= 1'h0;
        end
        else if (last_edge)
        begin
            word_tgl_reg <= !word_tgl_reg;
        end
    end

    // System domain, MCLK
    logic tgl_s1_reg;
    logic tgl_s2_reg;
    logic tgl_s3_reg;
    logic tgl_seen_reg;
    logic upd_s1_reg;
    logic upd_s2_reg;
    logic upd_s3_reg;
    logic upd_level_reg;
    logic pend_reg;
    load_word_t pend_word_reg;
    logic buf_ready_reg;
    code_t latch_reg [CHANNELS];
    code_t out_reg [CHANNELS];

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            tgl_s1_reg <= 1'h0;
            tgl_s2_reg <= 1'h0;
            tgl_s3_reg <= 1'h0;
            upd_s1_reg <= 1'h1;
            upd_s2_reg <= 1'h1;
            upd_s3_reg <= 1'h1;
        end
        else
        begin
            tgl_s1_reg <= word_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
            upd_s1_reg <= OUTPUT_UPDATE_N;
            upd_s2_reg <= upd_s1_reg;
            upd_s3_reg <= upd_s2_reg;
        end
    end

    wire tgl_agree = (tgl_s2_reg == tgl_s3_reg);
    wire word_event = tgl_agree && (tgl_s3_reg != tgl_seen_reg);
    wire upd_agree = (upd_s2_reg == upd_s3_reg);
    wire upd_fall = upd_agree && upd_level_reg && !upd_s3_reg;
    wire auto_mode = !upd_level_reg;

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            tgl_seen_reg <= 1'h0;
            upd_level_reg <= 1'h1;
        end
        else
        begin
            tgl_seen_reg <= tgl_agree ? tgl_s3_reg : tgl_seen_reg;
            upd_level_reg <= upd_agree ? upd_s3_reg : upd_level_reg;
        end
    end

    word_stream_if fill_s ();
    word_stream_if drain_s ();

    word_buffer u_buffer (
        .clk(MCLK),
        .rst(RST),
        .fill(fill_s.snk),
        .drain(drain_s.src)
    );

    // A word waits here while the buffer is full; the link cannot be stalled,
    // so a host outrunning two buffered words would overwrite this one
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            pend_reg <= 1'h0;
            pend_word_reg <= WORD_RESET;
        end
        else if (word_event)
        begin
            pend_reg <= 1'h1;
            pend_word_reg <= word_reg;
        end
        else if (fill_s.ready)
        begin
            pend_reg <= 1'h0;
        end
    end

    assign fill_s.valid = pend_reg;
    assign fill_s.data = pend_word_reg;
    // Draining pauses in the joint-update cycle so the outputs take settled latches
    assign drain_s.ready = !upd_fall;
    wire pop = drain_s.valid && drain_s.ready;
    wire pop_chan = chan_of(drain_s.data);
    wire [CODE_W-1:0] pop_code = code_of(drain_s.data);

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            buf_ready_reg <= 1'h0;
        end
        else
        begin
            buf_ready_reg <= fill_s.ready;
        end
    end

    for (genvar ch = 0; ch < CHANNELS; ch++)
    begin : g_chan
        wire hit = pop && (pop_chan == 1'(ch));

        always_ff @(posedge MCLK)
        begin
            if (RST)
            begin
                latch_reg[ch] <= CODE_RESET;
            end
            else if (hit)
            begin
                latch_reg[ch] <= pop_code;
            end
        end

        always_ff @(posedge MCLK)
        begin
            if (RST)
            begin
                out_reg[ch] <= CODE_RESET;
            end
            else if (upd_fall)
            begin
                out_reg[ch] <= latch_reg[ch];
            end
            else if (hit && auto_mode)
            begin
                out_reg[ch] <= pop_code;
            end
        end
    end

    assign CODE_A = out_reg[CHAN_A];
    assign CODE_B = out_reg[CHAN_B];
    assign BUF_READY = buf_ready_reg;

    // Checks
    sequence s_strobe_falls;
        upd_fall;
    endsequence

    sequence s_both_take_latches;
        (CODE_A == $past(latch_reg[CHAN_A])) && (CODE_B == $past(latch_reg[CHAN_B]));
    endsequence

    sequence s_loads_a;
        pop && (pop_chan == CHAN_A);
    endsequence

    property p_idle_count;
        @(posedge MCLK) disable iff (RST) HOST_FRAME_STROBE_N |-> bit_cnt_reg == CNT_ZERO;
    endproperty
    a_idle_count: assert property (p_idle_count) else $error("bit count not cleared outside frame");

    property p_shift_in;
        @(negedge SCLK) disable iff (RST || HOST_FRAME_STROBE_N)
            take_bit |=> shift_reg[0] == $past(SDATA);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("data bit not sampled on falling edge");

    // Judged at the first edge of the next frame, so the gap between frames must not disable it
    property p_word_capture;
        @(negedge SCLK) disable iff (RST)
            last_edge |=> (word_reg == {$past(shift_reg[WORD_W-2:0]), $past(SDATA)})
                && (word_tgl_reg != $past(word_tgl_reg));
    endproperty
    a_word_capture: assert property (p_word_capture) else $error("word not captured on 16th edge");

    property p_route_a;
        @(posedge MCLK) disable iff (RST)
            s_loads_a |=> latch_reg[CHAN_A] == $past(pop_code);
    endproperty
    a_route_a: assert property (p_route_a) else $error("select zero did not load channel A");

    property p_auto_update;
        @(posedge MCLK) disable iff (RST)
            (pop && auto_mode && pop_chan == CHAN_B) |=> CODE_B == $past(pop_code);
    endproperty
    a_auto_update: assert property (p_auto_update) else $error("automatic update missed");

    property p_hold_high;
        @(posedge MCLK) disable iff (RST)
            (upd_level_reg && !upd_fall) |=> $stable(CODE_A) && $stable(CODE_B);
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("output moved while update strobe high");

    property p_joint_update;
        @(posedge MCLK) disable iff (RST) s_strobe_falls |=> s_both_take_latches;
    endproperty
    a_joint_update: assert property (p_joint_update) else $error("outputs did not take latches together");

    property p_level_no_update;
        @(posedge MCLK) disable iff (RST)
            (!upd_level_reg [*2]) ##0 !pop |=> $stable(CODE_A) && $stable(CODE_B);
    endproperty
    a_level_no_update: assert property (p_level_no_update) else $error("low level alone moved outputs");

    property p_pending_held;
        @(posedge MCLK) disable iff (RST)
            (pend_reg && !fill_s.ready && !word_event) |=> pend_reg && $stable(pend_word_reg);
    endproperty
    a_pending_held: assert property (p_pending_held) else $error("stalled word dropped");

    property p_event_to_pending;
        @(posedge MCLK) disable iff (RST) word_event |=> pend_reg && pend_word_reg == $past(word_reg);
    endproperty
    a_event_to_pending: assert property (p_event_to_pending) else $error("completed word not taken");
endmodule

// ===== shared/dac_load_pkg.sv
// Constants and types shared by the dual converter serial load logic.
// Assumes a 16-bit frame with a channel select bit and a 12-bit code.
package dac_load_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CODE_W = 12;
    localparam int WORD_W = 13;
    localparam int SEL_POS = 12;
    localparam int CNT_W = 5;
    localparam int CHANNELS = 2;
    localparam int BUF_DEPTH = 2;
    localparam int PTR_W = 1;
    localparam int LEVEL_W = 2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_W-1:0] LAST_EDGE = 5'h0f;
    localparam logic [CNT_W-1:0] FRAME_DONE = 5'h10;
    localparam logic [LEVEL_W-1:0] LEVEL_EMPTY = 2'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_ONE = 2'h1;
    localparam logic [LEVEL_W-1:0] LEVEL_FULL = 2'h2;
    localparam logic [PTR_W-1:0] PTR_ZERO = 1'h0;
    localparam logic [PTR_W-1:0] PTR_LAST = 1'h1;
    localparam logic CHAN_A = 1'h0;
    localparam logic CHAN_B = 1'h1;
    localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
    localparam logic [WORD_W-1:0] WORD_RESET = 13'h0000;
    localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
    typedef logic [CODE_W-1:0] code_t;
    typedef logic [WORD_W-1:0] load_word_t;
endpackage

// ===== shared/word_stream_if.sv
// Valid/ready carrier for one loaded word (select bit and code).
// Assumes source and sink share one clock.
`timescale 1ns/1ps
interface word_stream_if;
    import dac_load_pkg::*;
    load_word_t data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// ===== hdl/word_buffer.sv
// Two-entry word buffer with valid and ready on both sides.
// Assumes a synchronous active-high reset on the same clock as both sides.
`timescale 1ns/1ps
module word_buffer
    import dac_load_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    word_stream_if.snk fill,
    word_stream_if.src drain
);
    load_word_t mem_reg [BUF_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [LEVEL_W-1:0] level_reg;
    logic [LEVEL_W-1:0] level_next;
    wire push = fill.valid && fill.ready;
    wire pop = drain.valid && drain.ready;

    assign fill.ready = (level_reg != LEVEL_FULL);
    assign drain.valid = (level_reg != LEVEL_EMPTY);
    assign drain.data = mem_reg[rd_ptr_reg];
    assign level_next = push && !pop ? level_reg + LEVEL_ONE :
                        pop && !push ? level_reg - LEVEL_ONE : level_reg;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= fill.data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_ptr_reg <= PTR_ZERO;
            rd_ptr_reg <= PTR_ZERO;
            level_reg <= LEVEL_EMPTY;
        end
        else
        begin
            wr_ptr_reg <= push ? wr_ptr_reg ^ PTR_LAST : wr_ptr_reg;
            rd_ptr_reg <= pop ? rd_ptr_reg ^ PTR_LAST : rd_ptr_reg;
            level_reg <= level_next;
        end
    end
endmodule

// ===== verif/host_serial_model.sv
// Behavioural host serial port that loads frames into the converter.
// Assumes the bench calls send_frame; the serial clock stands still high between frames.
`timescale 1ns/1ps
module host_serial_model (
    output logic sclk,
    output logic sdata,
    output logic frame_strobe_n
);
    // The frame line settles high only after reset has risen, so no clearing edge is lost at time zero
    initial
    begin
        sclk = 1'h1;
        sdata = 1'h0;
        #2 frame_strobe_n = 1'h1;
    end

    // Link period is 64 ns; data changes on the rising edge
    task automatic send_frame(input logic [15:0] word, input int bits, input bit byte_gap);
        // Odd offset keeps the link edges away from both edges of the system clock
        #3.3;
        frame_strobe_n = 1'b0;
        for (int i = 15; i > 15 - bits; i--)
        begin
            sdata = word[i];
            #32 sclk = 1'b0;
            #32 sclk = 1'b1;
            // A byte-wide host pauses between bytes but keeps the frame open
            if (byte_gap && i == 8)
                #200;
        end
        frame_strobe_n = 1'b1;
        // Released line must not look like the last bit
        sdata = ~sdata;
        #100;
    endtask
endmodule

// ===== verif/test_dual_dac_serial_load.sv
// Self-checking bench for the dual converter serial load block.
// Assumes the host model drives the link; the bench drives the update strobe.
`timescale 1ns/1ps
module test_dual_dac_serial_load;
    import dac_load_pkg::*;
    logic MCLK;
    logic RST;
    logic SCLK;
    logic SDATA;
    logic HOST_FRAME_STROBE_N;
    logic OUTPUT_UPDATE_N;
    logic [CODE_W-1:0] CODE_A;
    logic [CODE_W-1:0] CODE_B;
    logic BUF_READY;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    dual_dac_serial_load dual_dac_serial_load_i (
        .MCLK(MCLK),
        .RST(RST),
        .SCLK(SCLK),
        .SDATA(SDATA),
        .HOST_FRAME_STROBE_N(HOST_FRAME_STROBE_N),
        .OUTPUT_UPDATE_N(OUTPUT_UPDATE_N),
        .CODE_A(CODE_A),
        .CODE_B(CODE_B),
        .BUF_READY(BUF_READY)
    );

    host_serial_model host_serial_model_i (
        .sclk(SCLK),
        .sdata(SDATA),
        .frame_strobe_n(HOST_FRAME_STROBE_N)
    );

    initial
    begin
        MCLK = 1'b0;
        forever
            #4 MCLK = ~MCLK;
    end

    task automatic final_report();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // About 7 frames of roughly 1.1 us each; the ceiling leaves wide margin
    always @(posedge MCLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            final_report();
        end
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    task automatic set_update(input logic v);
        @(posedge MCLK);
        #1 OUTPUT_UPDATE_N = v;
        idle(6);
    endtask

    // Bounded wait until the chosen output shows the expected code
    task automatic wait_code(input logic chan, input logic [11:0] exp);
        int n;
        n = 0;
        while (((chan ? CODE_B : CODE_A) !== exp) && n < 60)
        begin
            idle(1);
            n++;
        end
    endtask

    task automatic t_reset();
        check(CODE_A, CODE_RESET);
        check(CODE_B, CODE_RESET);
        check({11'h000, BUF_READY}, 12'h001);
    endtask

    task automatic t_auto();
        set_update(1'b0);
        host_serial_model_i.send_frame({3'b111, CHAN_A, 12'ha5c}, 16, 1'b0);
        wait_code(CHAN_A, 12'ha5c);
        check(CODE_A, 12'ha5c);
        check(CODE_B, CODE_RESET);
        host_serial_model_i.send_frame({3'b010, CHAN_B, 12'h3c1}, 16, 1'b1);
        wait_code(CHAN_B, 12'h3c1);
        check(CODE_B, 12'h3c1);
        check(CODE_A, 12'ha5c);
    endtask

    // A frame cut short is dropped and the next one counts from bit one
    task automatic t_short();
        host_serial_model_i.send_frame({3'b000, CHAN_A, 12'hfff}, 10, 1'b0);
        idle(40);
        check(CODE_A, 12'ha5c);
        host_serial_model_i.send_frame({3'b101, CHAN_A, 12'h001}, 16, 1'b0);
        wait_code(CHAN_A, 12'h001);
        check(CODE_A, 12'h001);
    endtask

    task automatic t_joint();
        set_update(1'b1);
        host_serial_model_i.send_frame({3'b110, CHAN_A, 12'h123}, 16, 1'b0);
        host_serial_model_i.send_frame({3'b011, CHAN_B, 12'h456}, 16, 1'b0);
        idle(40);
        check(CODE_A, 12'h001);
        check(CODE_B, 12'h3c1);
        set_update(1'b0);
        wait_code(CHAN_A, 12'h123);
        check(CODE_A, 12'h123);
        check(CODE_B, 12'h456);
        set_update(1'h1);
        host_serial_model_i.send_frame({3'h2, CHAN_A, 12'h789}, 16, 1'h0);
        idle(40);
        check(CODE_A, 12'h123);
        set_update(1'h0);
        wait_code(CHAN_A, 12'h789);
        check(CODE_A, 12'h789);
        check(CODE_B, 12'h456);
    endtask

    initial
    begin
        // Reset rises after time zero so the edge-cleared link registers see it
        RST = 1'h0;
        OUTPUT_UPDATE_N = 1'h1;
        #1 RST = 1'h1;
        idle(10);
        RST = 1'b0;
        idle(4);
        t_reset();
        t_auto();
        t_short();
        t_joint();
        final_report();
    end
endmodule
